// [rtl/ogb_pkg.sv]
// Package of constants and types for the output serializer gearbox
// What this block does
// - Each cell serializes up to eight bits
// - Modes: 7:1, one 8:1, two 4:1
// - Word bits used follow the selected mode
// - Exactly three pipeline stages to output
// - Stage one captures the parallel word
// - Stage two transfers into shift domain
// - Stage three shifts bits onto outputs
package ogb_pkg;
  typedef enum logic [1:0] {
    OGB_MODE_VIDEO,
    OGB_MODE_QUAD,
    OGB_MODE_DUAL,
    OGB_MODE_SPARE
  } ogb_mode_t;
  localparam int OGB_WORD_W = 8;
  localparam int OGB_FIFO_DEPTH = 8;
  localparam int OGB_CNT_W = 3;
  // Last bit index of a frame, per mode
  localparam logic [2:0] OGB_LAST_VIDEO = 3'h6;
  localparam logic [2:0] OGB_LAST_QUAD = 3'h7;
  localparam logic [2:0] OGB_LAST_DUAL = 3'h3;
  // Lane masks; the video frame leaves the top bit unused
  localparam logic [7:0] OGB_MASK_VIDEO = 8'h7F;
  localparam logic [7:0] OGB_MASK_FULL = 8'hFF;
  // Start of the upper lane in dual mode
  localparam int OGB_LANE_B_POS = 4;
  localparam logic [7:0] OGB_WORD_RST = 8'h00;
  localparam logic [2:0] OGB_CNT_RST = 3'h0;
endpackage

// [rtl/ogb_stream_if.sv]
// Word stream carrier between the FIFO and the gearbox pipeline
`timescale 1ns/10ps
`default_nettype none
interface ogb_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // ogb_stream_if
`default_nettype wire

// [rtl/ogb_fifo.sv]
// Word FIFO with registered read data ahead of the gearbox
`timescale 1ns/10ps
`default_nettype none
module ogb_fifo import ogb_pkg::*; #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Filling side
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  ogb_stream_if.src out
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic in_ready_reg;
  logic out_valid_reg;
  logic [W-1:0] out_data_reg;
  logic push;
  logic pop;

  // Pop refills the output register whenever it is free or taken
  assign push = in_valid && in_ready_reg;
  assign pop = (count_reg != '0) && (!out_valid_reg || out.ready);
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = in_ready_reg;
  assign out.valid = out_valid_reg;
  assign out.data = out_data_reg;

  // Storage has no reset; only written entries are ever read
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, fill count and a registered ready
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b0;
    end else if (ce) begin
      if (push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop) rd_ptr_reg <= rd_ptr_reg + AW'(1);
      count_reg <= count_next;
      in_ready_reg <= (count_next != (AW+1)'(DEPTH));
    end
  end

  // Registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else if (ce) begin
      if (pop) begin
        out_valid_reg <= 1'b1;
        out_data_reg <= mem[rd_ptr_reg];
      end else if (out.ready) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_fifo_no_overflow: assert property (
    count_reg == (AW+1)'(DEPTH) |-> !in_ready_reg)
    else $error("FIFO accepts while full");
  a_fifo_hold_data: assert property (
    out_valid_reg && !out.ready |=> out_valid_reg &&
    $stable(out_data_reg))
    else $error("FIFO output changed while stalled");
endmodule // ogb_fifo
`default_nettype wire

// [rtl/ogb_gearbox.sv]
// Output serializer gearbox top: FIFO, three stages, serial outputs
`timescale 1ns/10ps
`default_nettype none
module ogb_gearbox import ogb_pkg::*; (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Mode select, change only while idle
  input wire logic [1:0] mode,
  // Parallel words from the core
  input wire logic [OGB_WORD_W-1:0] word_in,
  input wire logic word_valid,
  output logic word_ready,
  // Serial outputs to the output buffers, and the busy flag
  output logic q_first,
  output logic q_second,
  output logic busy
);
  ogb_stream_if #(.W(OGB_WORD_W)) fifo_out ();
  ogb_mode_t mode_sel;
  logic [OGB_WORD_W-1:0] s1_word_reg;
  logic s1_valid_reg;
  logic [OGB_WORD_W-1:0] s2_word_reg;
  logic s2_valid_reg;
  logic [OGB_WORD_W-1:0] s3_shift_reg;
  logic [OGB_WORD_W-1:0] s3_shift_next;
  logic s3_active_reg;
  logic [OGB_CNT_W-1:0] bit_cnt_reg;
  logic [OGB_CNT_W-1:0] last_bit;
  logic [OGB_WORD_W-1:0] lane_mask;
  logic s3_load;
  logic s2_take;
  logic s1_take;
  logic busy_reg;

  // The FIFO soaks up bursts while a frame is still shifting
  ogb_fifo #(.W(OGB_WORD_W), .DEPTH(OGB_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_data(word_in),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .out(fifo_out)
  );

  // Frame length and used lanes follow the mode
  // Mode must stay put mid-frame: the frame end is compared live
  always_comb begin
    mode_sel = ogb_mode_t'(mode);
    case (mode_sel)
      OGB_MODE_VIDEO: begin
        last_bit = OGB_LAST_VIDEO;
        lane_mask = OGB_MASK_VIDEO;
      end
      OGB_MODE_DUAL: begin
        last_bit = OGB_LAST_DUAL;
        lane_mask = OGB_MASK_FULL;
      end
      default: begin
        last_bit = OGB_LAST_QUAD;
        lane_mask = OGB_MASK_FULL;
      end
    endcase
  end

  // A stage moves on whenever the stage after it is free or moving
  // Chaining the takes keeps frames back to back with no idle bit,
  // at the cost of one long combinational path from stage three
  assign s3_load = !s3_active_reg || (bit_cnt_reg == last_bit);
  assign s2_take = !s2_valid_reg || s3_load;
  assign s1_take = !s1_valid_reg || s2_take;
  assign fifo_out.ready = s1_take;

  // Stage one: capture the parallel word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_word_reg <= OGB_WORD_RST;
      s1_valid_reg <= 1'b0;
    end else if (ce && s1_take) begin
      s1_word_reg <= fifo_out.data & lane_mask;
      s1_valid_reg <= fifo_out.valid;
    end
  end

  // Stage two: hand the word over to the shift side
  // One clock serves both sides, so this is a plain transfer; split
  // clocks would need a handshake or gray coding across this stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s2_word_reg <= OGB_WORD_RST;
      s2_valid_reg <= 1'b0;
    end else if (ce && s2_take) begin
      s2_word_reg <= s1_word_reg;
      s2_valid_reg <= s1_valid_reg;
    end
  end

  // Dual mode shifts each nibble on its own lane
  always_comb begin
    if (mode_sel == OGB_MODE_DUAL) begin
      s3_shift_next = {1'b0, s3_shift_reg[7:5], 1'b0, s3_shift_reg[3:1]};
    end else begin
      s3_shift_next = {1'b0, s3_shift_reg[7:1]};
    end
  end

  // Stage three: shift out LSB first; runs dry to all zeros
  // Zeros enter from the top so a lane falls low when its frame ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s3_shift_reg <= OGB_WORD_RST;
      s3_active_reg <= 1'b0;
      bit_cnt_reg <= OGB_CNT_RST;
    end else if (ce) begin
      if (s3_load) begin
        s3_shift_reg <= s2_valid_reg ? s2_word_reg : OGB_WORD_RST;
        s3_active_reg <= s2_valid_reg;
        bit_cnt_reg <= OGB_CNT_RST;
      end else begin
        s3_shift_reg <= s3_shift_next;
        bit_cnt_reg <= bit_cnt_reg + OGB_CNT_W'(1);
      end
    end
  end

  // Outputs come straight off the shift register flops
  assign q_first = s3_shift_reg[0];
  assign q_second = s3_shift_reg[OGB_LANE_B_POS];

  // Busy while any stage or the FIFO read register holds a word
  // It lags the stages by one cycle; callers must allow for that
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else if (ce) begin
      busy_reg <= s1_valid_reg || s2_valid_reg || s3_active_reg ||
        fifo_out.valid;
    end
  end
  assign busy = busy_reg;

  // Checks run on the one clock and sleep through reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_capture;
    ce && fifo_out.valid && s1_take;
  endsequence

  sequence seq_load;
    ce && s3_load && s2_valid_reg;
  endsequence

  sequence seq_shift;
    ce && s3_active_reg && !s3_load;
  endsequence

  // Capture and hand-over checks
  a_stage1_capture: assert property (
    seq_capture |=> s1_valid_reg &&
    s1_word_reg == ($past(fifo_out.data) & $past(lane_mask)))
    else $error("Stage one missed the word");
  a_stage2_xfer: assert property (
    ce && s2_take && s1_valid_reg |=> s2_word_reg == $past(s1_word_reg))
    else $error("Stage two missed the word");
  a_stage3_load: assert property (
    seq_load |=> s3_active_reg && bit_cnt_reg == OGB_CNT_RST &&
    q_first == $past(s2_word_reg[0]))
    else $error("Stage three load wrong");
  a_three_stage: assert property (
    seq_capture ##1 (ce && s2_take) ##1 (ce && s3_load) |=>
    s3_shift_reg == $past(s1_word_reg, 2))
    else $error("Pipeline depth is not three stages");
  // Frame shape checks
  a_idle_low: assert property (
    !s3_active_reg |-> !q_first && !q_second)
    else $error("Output not low while idle");
  a_count_bound: assert property (
    s3_active_reg |-> bit_cnt_reg <= last_bit)
    else $error("Bit count past frame end");
  a_video_msb: assert property (
    mode_sel == OGB_MODE_VIDEO && s3_active_reg |-> !s3_shift_reg[7])
    else $error("Video frame carries bit seven");
  a_dual_lane: assert property (
    (seq_load and (mode_sel == OGB_MODE_DUAL)) |=>
    q_second == $past(s2_word_reg[OGB_LANE_B_POS]))
    else $error("Second lane not loaded from upper nibble");
  a_shift_step: assert property (
    ce && s3_active_reg && !s3_load && mode_sel == OGB_MODE_QUAD |=>
    q_first == $past(s3_shift_reg[1]))
    else $error("Shift step wrong");

  // Lane steps in the narrower modes, and the bit count step in every mode
  a_video_step: assert property (
    (seq_shift and (mode_sel == OGB_MODE_VIDEO)) |=>
    q_first == $past(s3_shift_reg[1]))
    else $error("Video shift step wrong");
  a_dual_step: assert property (
    (seq_shift and (mode_sel == OGB_MODE_DUAL)) |=>
    q_first == $past(s3_shift_reg[1]) &&
    q_second == $past(s3_shift_reg[OGB_LANE_B_POS + 1]))
    else $error("Dual lanes did not step together");
  a_count_step: assert property (
    seq_shift |=> bit_cnt_reg == $past(bit_cnt_reg) + OGB_CNT_W'(1))
    else $error("Bit count did not advance");
  // A frame that ends with nothing queued leaves the lanes low
  a_run_dry: assert property (
    ce && s3_load && !s2_valid_reg |=>
    !s3_active_reg && s3_shift_reg == OGB_WORD_RST)
    else $error("Lanes not cleared after the last frame");
  // A low enable freezes every stage
  a_ce_freeze: assert property (
    !ce |=> $stable(s1_word_reg) && $stable(s2_word_reg) &&
    $stable(s3_shift_reg) && $stable(bit_cnt_reg))
    else $error("Pipeline moved with the enable low");
  // Frames follow one another with no idle bit between them
  a_back_to_back: assert property (
    ce && s3_active_reg && bit_cnt_reg == last_bit && s2_valid_reg |=>
    s3_active_reg && bit_cnt_reg == OGB_CNT_RST)
    else $error("Gap between queued frames");
endmodule // ogb_gearbox
`default_nettype wire

// [verif/ogb_rx_model.sv]
// Receiver model that samples both serial lanes at mid-bit
`timescale 1ns/10ps
`default_nettype none
module ogb_rx_model (
  // Clock
  input wire logic clk,
  // Serial lanes from the gearbox
  input wire logic q_first,
  input wire logic q_second,
  // Bit histories, newest bit at the top
  output logic [31:0] hist_first,
  output logic [31:0] hist_second
);
  // Cleared at start so idle lanes read as zeros
  initial begin
    hist_first = 32'h0;
    hist_second = 32'h0;
  end
  // Falling edge sits mid-bit, clear of the launching edge
  always @(negedge clk) begin
    hist_first <= {q_first, hist_first[31:1]};
    hist_second <= {q_second, hist_second[31:1]};
  end
endmodule // ogb_rx_model
`default_nettype wire

// [verif/ogb_gearbox_tb.sv]
// Self-checking bench for the output serializer gearbox
`timescale 1ns/10ps
`default_nettype none
module ogb_gearbox_tb;
  import ogb_pkg::*;
  logic clk, rst_n, ce, word_valid, seen_full;
  logic [1:0] mode;
  logic [7:0] word_in;
  wire logic word_ready, q_first, q_second, busy;
  wire logic [31:0] hist_first, hist_second;
  int error_cnt = 0;
  int compares = 0;

  ogb_gearbox DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .mode(mode),
    .word_in(word_in), .word_valid(word_valid), .word_ready(word_ready),
    .q_first(q_first), .q_second(q_second), .busy(busy));
  ogb_rx_model rx (.clk(clk), .q_first(q_first), .q_second(q_second),
    .hist_first(hist_first), .hist_second(hist_second));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Notes any edge at which a word was held back
  always @(posedge clk) if (word_valid && !word_ready) seen_full <= 1'b1;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d, compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Offer one word and return on the edge that takes it
  task automatic put(input logic [7:0] w);
    int n;
    @(negedge clk);
    word_valid = 1'b1;
    word_in = w;
    n = 0;
    while (word_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(16'(word_ready), 16'h1);
    @(posedge clk);
  endtask

  // Busy lags one cycle, so a little slack follows it
  task automatic idle();
    int n;
    @(negedge clk);
    word_valid = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(16'(busy), 16'h0);
    repeat (2) @(negedge clk);
  endtask

  // Two words back to back in one mode; exact latency is implied
  task automatic frames(input logic [1:0] m, input logic [7:0] w0,
      input logic [7:0] w1, input int n, input logic [15:0] ef,
      input logic [15:0] es);
    mode = m;
    put(w0);
    put(w1);
    @(negedge clk);
    word_valid = 1'b0;
    repeat (3) @(posedge clk);
    repeat (2 * n) @(negedge clk);
    #1;
    chk(16'(hist_first >> (32 - 2 * n)), ef);
    if (m == 2'h2) chk(16'(hist_second >> 24), es);
    idle();
  endtask

  // Overfill the FIFO, then freeze the clock enable mid-frame
  task automatic fill_and_freeze();
    logic q;
    mode = 2'h1;
    seen_full = 1'b0;
    for (int i = 0; i < 16; i++) put(8'(i));
    chk(16'(seen_full), 16'h1);
    @(negedge clk);
    ce = 1'b0;
    word_valid = 1'b0;
    q = q_first;
    repeat (4) begin
      @(negedge clk);
      chk(16'({q_first, busy}), 16'({q, 1'b1}));
    end
    ce = 1'b1;
    idle();
    chk(16'({q_first, q_second, word_ready}), 16'h1);
  endtask

  // Reset mid-frame must clear the pipeline and hold the lanes low
  task automatic reset_mid();
    mode = 2'h1;
    put(8'hFF);
    repeat (6) @(negedge clk);
    word_valid = 1'b0;
    rst_n = 1'b0;
    #1;
    chk(16'({q_first, q_second, busy, word_ready}), 16'h0);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    #1;
    chk(16'(hist_first >> 20), 16'h0);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    mode = 2'h1;
    word_in = 8'h00;
    word_valid = 1'b0;
    seen_full = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(16'({q_first, q_second, busy, word_ready}), 16'h0);
    rst_n = 1'b1;
    @(negedge clk);
    chk(16'(word_ready), 16'h1);
    frames(2'h1, 8'hA5, 8'h3C, 8, 16'h3CA5, 16'h0);
    frames(2'h3, 8'h5A, 8'hC3, 8, 16'hC35A, 16'h0);
    frames(2'h0, 8'hFF, 8'h80, 7, 16'h007F, 16'h0);
    frames(2'h2, 8'h9C, 8'h36, 4, 16'h006C, 16'h0039);
    fill_and_freeze();
    reset_mid();
    finish_test();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end
endmodule // ogb_gearbox_tb
`default_nettype wire
